// >>> rtl/motion_cfg_pkg.sv
// constants for the motion sensor configuration register bank
package motion_cfg_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int FILL_W = 13;
  // register offsets
  localparam logic [7:0] OFF_ACC_CFG = 8'h40;
  localparam logic [7:0] OFF_ACC_SCALE = 8'h41;
  localparam logic [7:0] OFF_GYR_CFG = 8'h42;
  localparam logic [7:0] OFF_GYR_SCALE = 8'h43;
  localparam logic [7:0] OFF_AUX_CFG = 8'h44;
  localparam logic [7:0] OFF_DECIM = 8'h45;
  localparam logic [7:0] OFF_THR_LO = 8'h46;
  localparam logic [7:0] OFF_THR_HI = 8'h47;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h60;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h61;
  localparam logic [7:0] OFF_CFG_ERR = 8'h62;
  // reset values
  localparam logic [7:0] RST_ACC_CFG = 8'hA8;
  localparam logic [7:0] RST_ACC_SCALE = 8'h02;
  localparam logic [7:0] RST_GYR_CFG = 8'hA9;
  localparam logic [7:0] RST_GYR_SCALE = 8'h00;
  localparam logic [7:0] RST_AUX_CFG = 8'h46;
  localparam logic [7:0] RST_DECIM = 8'h88;
  localparam logic [7:0] RST_THR_LO = 8'h00;
  localparam logic [7:0] RST_THR_HI = 8'h02;
  // writable bit masks (reserved bits read zero)
  localparam logic [7:0] MSK_ACC_SCALE = 8'h03;
  localparam logic [7:0] MSK_GYR_SCALE = 8'h0F;
  localparam logic [7:0] MSK_THR_HI = 8'h1F;
  // field positions
  localparam int ACC_PERF_BIT = 7;
  localparam int GYR_NOISE_BIT = 6;
  localparam int GYR_FPERF_BIT = 7;
  localparam int GYR_OIS_BIT = 3;
  localparam int GYR_FILT_BIT = 3;
  localparam int ACC_FILT_BIT = 7;
  // rate, bandwidth, scale and offset code limits
  localparam logic [3:0] ACC_RATE_MIN = 4'h1;
  localparam logic [3:0] ACC_RATE_MAX = 4'hC;
  localparam logic [3:0] GYR_RATE_MIN = 4'h6;
  localparam logic [3:0] GYR_RATE_MAX = 4'hD;
  localparam logic [3:0] AUX_RATE_MIN = 4'h1;
  localparam logic [3:0] AUX_RATE_MAX = 4'hB;
  localparam logic [2:0] ACC_BW_MAX_PERF = 3'h3;
  localparam logic [1:0] GYR_BW_MAX = 2'h2;
  localparam logic [2:0] GYR_SCALE_MAX = 3'h4;
  localparam logic [3:0] AUX_OFS_MAX = 4'hF;
  // interrupt status bit positions
  localparam int IRQ_WTM = 0;
  localparam int IRQ_CFG = 1;
  localparam int IRQ_W = 2;
  // configuration error bit positions
  localparam int ERR_ACC_RATE = 0;
  localparam int ERR_ACC_BW = 1;
  localparam int ERR_GYR_RATE = 2;
  localparam int ERR_GYR_BW = 3;
  localparam int ERR_GYR_SCALE = 4;
  localparam int ERR_AUX_RATE = 5;
  localparam int ERR_W = 6;
  // auxiliary trigger offset timing
  localparam int AUX_UNIT_US = 2500;
  localparam int CLK_MHZ = 40;
  localparam int AUX_UNIT_CYC = AUX_UNIT_US * CLK_MHZ;
  // filter mode selection
  typedef enum logic [1:0] {
    ACC_OSR4 = 2'b00,
    ACC_OSR2 = 2'b01,
    ACC_NORM = 2'b10,
    ACC_CIC = 2'b11
  } acc_filter_t;
endpackage : motion_cfg_pkg

// >>> rtl/motion_sensor_config_regs.sv
// configuration register bank of the motion sensor with decoded settings
//
// Our own choice: the plain strobed port.
module motion_sensor_config_regs
  import motion_cfg_pkg::*;
#(
  parameter int AUX_UNIT_CYCLES = AUX_UNIT_CYC
)
(
  // clock, reset, enable
  input wire logic CLK_I,
  input wire logic RSTN_I,
  input wire logic CE_I,
  // register port
  input wire logic [ADDR_W-1:0] ADDR_I,
  input wire logic [DATA_W-1:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [DATA_W-1:0] RDATA_O,
  // buffer fill and auxiliary readout from the datapath
  input wire logic [FILL_W-1:0] FILL_BYTES_I,
  input wire logic AUX_READOUT_I,
  // decoded accelerometer settings
  output logic [3:0] ACC_RATE_O,
  output logic ACC_RATE_VALID_O,
  output logic ACC_PERF_O,
  output logic [1:0] ACC_FILTER_O,
  output logic [2:0] ACC_AVG_LOG2_O,
  output logic [1:0] ACC_RANGE_O,
  // decoded gyroscope settings
  output logic [3:0] GYR_RATE_O,
  output logic GYR_RATE_VALID_O,
  output logic [1:0] GYR_BW_O,
  output logic GYR_NOISE_PERF_O,
  output logic GYR_FILTER_PERF_O,
  output logic [2:0] GYR_RANGE_O,
  output logic GYR_OIS_WIDE_O,
  // auxiliary interface
  output logic [3:0] AUX_RATE_O,
  output logic AUX_RATE_VALID_O,
  output logic AUX_TRIGGER_O,
  // buffer settings
  output logic [2:0] GYR_DOWNS_O,
  output logic [2:0] ACC_DOWNS_O,
  output logic GYR_FILT_SEL_O,
  output logic ACC_FILT_SEL_O,
  output logic [FILL_W-1:0] WTM_LEVEL_O,
  // interrupt
  output logic IRQ_O
);

  logic [7:0] acc_cfg;
  logic [7:0] acc_scale;
  logic [7:0] gyr_cfg;
  logic [7:0] gyr_scale;
  logic [7:0] aux_cfg;
  logic [7:0] decim;
  logic [7:0] thr_lo;
  logic [7:0] thr_hi;
  logic [IRQ_W-1:0] irq_stat;
  logic [IRQ_W-1:0] irq_mask;
  logic [ERR_W-1:0] cfg_err;
  logic [FILL_W-1:0] wtm_level;
  logic wtm_hit;
  logic wtm_hit_q;
  logic cfg_bad;
  logic cfg_bad_q;
  logic [IRQ_W-1:0] irq_event;
  logic wr_stat;
  logic [3:0] ofs_units;
  logic [31:0] unit_cnt;
  logic [3:0] unit_left;
  logic aux_wait;
  logic [7:0] next_rdata;

  // writable configuration registers
  always_ff @(posedge CLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      acc_cfg <= RST_ACC_CFG;
      acc_scale <= RST_ACC_SCALE;
      gyr_cfg <= RST_GYR_CFG;
      gyr_scale <= RST_GYR_SCALE;
      aux_cfg <= RST_AUX_CFG;
      decim <= RST_DECIM;
      thr_lo <= RST_THR_LO;
      thr_hi <= RST_THR_HI;
      irq_mask <= '0;
    end
    else if (CE_I && WR_I)
    begin
      case (ADDR_I)
        OFF_ACC_CFG: acc_cfg <= WDATA_I;
        OFF_ACC_SCALE: acc_scale <= WDATA_I & MSK_ACC_SCALE;
        OFF_GYR_CFG: gyr_cfg <= WDATA_I;
        OFF_GYR_SCALE: gyr_scale <= WDATA_I & MSK_GYR_SCALE;
        OFF_AUX_CFG: aux_cfg <= WDATA_I;
        OFF_DECIM: decim <= WDATA_I;
        OFF_THR_LO: thr_lo <= WDATA_I;
        OFF_THR_HI: thr_hi <= WDATA_I & MSK_THR_HI;
        OFF_IRQ_MASK: irq_mask <= WDATA_I[IRQ_W-1:0];
        default: ;
      endcase
    end
  end

  // watermark compare; event on reaching the threshold
  assign wtm_level = {thr_hi[4:0], thr_lo};
  assign wtm_hit = (FILL_BYTES_I >= wtm_level);

  // reserved code detection
  always_comb
  begin
    cfg_err = '0;
    cfg_err[ERR_ACC_RATE] = (acc_cfg[3:0] < ACC_RATE_MIN) ||
                            (acc_cfg[3:0] > ACC_RATE_MAX);
    cfg_err[ERR_ACC_BW] = acc_cfg[ACC_PERF_BIT] &&
                          (acc_cfg[6:4] > ACC_BW_MAX_PERF);
    cfg_err[ERR_GYR_RATE] = (gyr_cfg[3:0] < GYR_RATE_MIN) ||
                            (gyr_cfg[3:0] > GYR_RATE_MAX);
    cfg_err[ERR_GYR_BW] = (gyr_cfg[5:4] > GYR_BW_MAX);
    cfg_err[ERR_GYR_SCALE] = (gyr_scale[2:0] > GYR_SCALE_MAX);
    cfg_err[ERR_AUX_RATE] = (aux_cfg[3:0] < AUX_RATE_MIN) ||
                            (aux_cfg[3:0] > AUX_RATE_MAX);
  end
  assign cfg_bad = |cfg_err;

  always_ff @(posedge CLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      wtm_hit_q <= 1'b0;
      cfg_bad_q <= 1'b0;
    end
    else if (CE_I)
    begin
      wtm_hit_q <= wtm_hit;
      cfg_bad_q <= cfg_bad;
    end
  end

  assign irq_event[IRQ_WTM] = wtm_hit && !wtm_hit_q;
  assign irq_event[IRQ_CFG] = cfg_bad && !cfg_bad_q;
  assign wr_stat = WR_I && (ADDR_I == OFF_IRQ_STAT);

  // sticky status, write one to clear, a new event wins over clear
  always_ff @(posedge CLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
      irq_stat <= '0;
    else if (CE_I)
    begin
      if (wr_stat)
        irq_stat <= (irq_stat & ~WDATA_I[IRQ_W-1:0]) | irq_event;
      else
        irq_stat <= irq_stat | irq_event;
    end
  end

  // auxiliary trigger placed a number of 2.5 ms units after readout
  assign ofs_units = (aux_cfg[7:4] == 4'h0) ? 4'h0 : aux_cfg[7:4];

  always_ff @(posedge CLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      aux_wait <= 1'b0;
      unit_cnt <= '0;
      unit_left <= '0;
      AUX_TRIGGER_O <= 1'b0;
    end
    else if (CE_I)
    begin
      AUX_TRIGGER_O <= 1'b0;
      if (AUX_READOUT_I)
      begin
        // zero offset: trigger right after the readout
        if (ofs_units == 4'h0)
        begin
          AUX_TRIGGER_O <= 1'b1;
          aux_wait <= 1'b0;
        end
        else
        begin
          aux_wait <= 1'b1;
          unit_left <= ofs_units;
          unit_cnt <= '0;
        end
      end
      else if (aux_wait)
      begin
        if (unit_cnt == 32'(AUX_UNIT_CYCLES - 1))
        begin
          unit_cnt <= '0;
          if (unit_left == 4'h1)
          begin
            aux_wait <= 1'b0;
            AUX_TRIGGER_O <= 1'b1;
          end
          unit_left <= unit_left - 4'h1;
        end
        else
          unit_cnt <= unit_cnt + 32'h0000_0001;
      end
    end
  end

  // read mux
  always_comb
  begin
    next_rdata = 8'h00;
    case (ADDR_I)
      OFF_ACC_CFG: next_rdata = acc_cfg;
      OFF_ACC_SCALE: next_rdata = acc_scale;
      OFF_GYR_CFG: next_rdata = gyr_cfg;
      OFF_GYR_SCALE: next_rdata = gyr_scale;
      OFF_AUX_CFG: next_rdata = aux_cfg;
      OFF_DECIM: next_rdata = decim;
      OFF_THR_LO: next_rdata = thr_lo;
      OFF_THR_HI: next_rdata = thr_hi;
      OFF_IRQ_STAT: next_rdata = {6'h00, irq_stat};
      OFF_IRQ_MASK: next_rdata = {6'h00, irq_mask};
      OFF_CFG_ERR: next_rdata = {2'h0, cfg_err};
      default: next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge CLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
      RDATA_O <= 8'h00;
    else if (CE_I && RD_I)
      RDATA_O <= next_rdata;
  end

  // registered decoded settings
  always_ff @(posedge CLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      ACC_RATE_O <= '0;
      ACC_RATE_VALID_O <= 1'b0;
      ACC_PERF_O <= 1'b0;
      ACC_FILTER_O <= '0;
      ACC_AVG_LOG2_O <= '0;
      ACC_RANGE_O <= '0;
      GYR_RATE_O <= '0;
      GYR_RATE_VALID_O <= 1'b0;
      GYR_BW_O <= '0;
      GYR_NOISE_PERF_O <= 1'b0;
      GYR_FILTER_PERF_O <= 1'b0;
      GYR_RANGE_O <= '0;
      GYR_OIS_WIDE_O <= 1'b0;
      AUX_RATE_O <= '0;
      AUX_RATE_VALID_O <= 1'b0;
      GYR_DOWNS_O <= '0;
      ACC_DOWNS_O <= '0;
      GYR_FILT_SEL_O <= 1'b0;
      ACC_FILT_SEL_O <= 1'b0;
      WTM_LEVEL_O <= '0;
      IRQ_O <= 1'b0;
    end
    else if (CE_I)
    begin
      ACC_RATE_O <= acc_cfg[3:0];
      ACC_RATE_VALID_O <= !cfg_err[ERR_ACC_RATE];
      ACC_PERF_O <= acc_cfg[ACC_PERF_BIT];
      // bandwidth meaning depends on the performance mode bit
      ACC_FILTER_O <= acc_cfg[ACC_PERF_BIT] ?
                      acc_cfg[5:4] : 2'(ACC_NORM);
      ACC_AVG_LOG2_O <= acc_cfg[ACC_PERF_BIT] ?
                        3'h0 : acc_cfg[6:4];
      ACC_RANGE_O <= acc_scale[1:0];
      GYR_RATE_O <= gyr_cfg[3:0];
      GYR_RATE_VALID_O <= !cfg_err[ERR_GYR_RATE];
      GYR_BW_O <= gyr_cfg[5:4];
      GYR_NOISE_PERF_O <= gyr_cfg[GYR_NOISE_BIT];
      GYR_FILTER_PERF_O <= gyr_cfg[GYR_FPERF_BIT];
      GYR_RANGE_O <= gyr_scale[2:0];
      GYR_OIS_WIDE_O <= gyr_scale[GYR_OIS_BIT];
      AUX_RATE_O <= aux_cfg[3:0];
      AUX_RATE_VALID_O <= !cfg_err[ERR_AUX_RATE];
      GYR_DOWNS_O <= decim[2:0];
      ACC_DOWNS_O <= decim[6:4];
      GYR_FILT_SEL_O <= decim[GYR_FILT_BIT];
      ACC_FILT_SEL_O <= decim[ACC_FILT_BIT];
      WTM_LEVEL_O <= wtm_level;
      IRQ_O <= |(next_irq_stat() & irq_mask);
    end
  end

  // status value that the sticky register takes at this edge
  function automatic logic [IRQ_W-1:0] next_irq_stat();
    if (wr_stat)
      return (irq_stat & ~WDATA_I[IRQ_W-1:0]) | irq_event;
    return irq_stat | irq_event;
  endfunction : next_irq_stat

endmodule : motion_sensor_config_regs

// >>> testbench/motion_cfg_checker.sv
// assertion checker for the motion sensor configuration register bank
module motion_cfg_checker
  import motion_cfg_pkg::*;
#(
  parameter int AUX_UNIT_CYCLES = 4
)
(
  // clock, reset and register port
  input wire logic CLK_I,
  input wire logic RSTN_I,
  input wire logic [ADDR_W-1:0] ADDR_I,
  input wire logic [DATA_W-1:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  input wire logic [DATA_W-1:0] RDATA_O,
  // datapath events
  input wire logic [FILL_W-1:0] FILL_BYTES_I,
  input wire logic AUX_READOUT_I,
  // decoded settings
  input wire logic [3:0] ACC_RATE_O,
  input wire logic ACC_RATE_VALID_O,
  input wire logic ACC_PERF_O,
  input wire logic [1:0] ACC_FILTER_O,
  input wire logic [2:0] ACC_AVG_LOG2_O,
  input wire logic [3:0] GYR_RATE_O,
  input wire logic GYR_RATE_VALID_O,
  input wire logic [FILL_W-1:0] WTM_LEVEL_O,
  input wire logic AUX_TRIGGER_O,
  input wire logic IRQ_O
);
  logic [7:0] acc_w;
  logic [7:0] aux_w;
  logic [7:0] msk_w;
  logic above;

  // shadow copies of the registers the properties depend on
  always_ff @(posedge CLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      acc_w <= 8'hA8;
      aux_w <= 8'h46;
      msk_w <= 8'h00;
      above <= 1'b0;
    end
    else
    begin
      if (WR_I && ADDR_I == OFF_ACC_CFG) acc_w <= WDATA_I;
      if (WR_I && ADDR_I == OFF_AUX_CFG) aux_w <= WDATA_I;
      if (WR_I && ADDR_I == OFF_IRQ_MASK) msk_w <= WDATA_I;
      above <= FILL_BYTES_I >= WTM_LEVEL_O;
    end
  end

  default clocking @(posedge CLK_I); endclocking
  default disable iff (!RSTN_I);

  sequence acc_wr_s;
    (WR_I && ADDR_I == OFF_ACC_CFG) ##1 !(WR_I && ADDR_I == OFF_ACC_CFG);
  endsequence

  a_acc_rate_valid: assert property (
    ACC_RATE_VALID_O == (ACC_RATE_O inside {[ACC_RATE_MIN:ACC_RATE_MAX]}))
    else $error("accel rate valid flag wrong");
  a_gyr_rate_valid: assert property (
    GYR_RATE_VALID_O == (GYR_RATE_O inside {[GYR_RATE_MIN:GYR_RATE_MAX]}))
    else $error("gyro rate valid flag wrong");
  a_acc_cfg_follow: assert property (acc_wr_s |=>
    ACC_PERF_O == acc_w[7] && ACC_RATE_O == acc_w[3:0])
    else $error("accel config not applied");
  a_acc_bw_decode: assert property (acc_wr_s |=>
    (acc_w[7] ? (acc_w[6] || ACC_FILTER_O == acc_w[5:4])
              : ACC_AVG_LOG2_O == acc_w[6:4]))
    else $error("accel bandwidth decode wrong");
  a_range_reserved: assert property (
    RD_I && ADDR_I == OFF_ACC_SCALE |=> RDATA_O[7:2] == 6'h00)
    else $error("accel range reserved bits not zero");
  a_wtm_low_byte: assert property (
    WR_I && ADDR_I == OFF_THR_LO |-> ##2 WTM_LEVEL_O[7:0] == $past(WDATA_I, 2))
    else $error("watermark low byte not applied");
  a_wtm_irq_rise: assert property (
    FILL_BYTES_I >= WTM_LEVEL_O && !above && msk_w[0] |=> IRQ_O)
    else $error("watermark crossing gave no interrupt");
  a_irq_masked: assert property ((msk_w == 8'h00)[*2] |-> !IRQ_O)
    else $error("interrupt with all sources masked");
  a_aux_immediate: assert property (
    AUX_READOUT_I && aux_w[7:4] == 4'h0 |=> AUX_TRIGGER_O)
    else $error("zero offset trigger not immediate");
  a_aux_one_pulse: assert property (
    AUX_TRIGGER_O && aux_w[7:4] != 4'h0 |=> !AUX_TRIGGER_O)
    else $error("aux trigger longer than one cycle");

  c_irq: cover property (IRQ_O);
  c_aux: cover property (AUX_TRIGGER_O);
  c_bad_rate: cover property (!ACC_RATE_VALID_O ##1 ACC_RATE_VALID_O);
endmodule : motion_cfg_checker

bind motion_sensor_config_regs motion_cfg_checker
  #(.AUX_UNIT_CYCLES(AUX_UNIT_CYCLES)) i_chk (.CLK_I, .RSTN_I, .ADDR_I,
  .WDATA_I, .WR_I, .RD_I, .RDATA_O, .FILL_BYTES_I, .AUX_READOUT_I,
  .ACC_RATE_O, .ACC_RATE_VALID_O, .ACC_PERF_O, .ACC_FILTER_O, .ACC_AVG_LOG2_O,
  .GYR_RATE_O, .GYR_RATE_VALID_O, .WTM_LEVEL_O, .AUX_TRIGGER_O, .IRQ_O);

// >>> testbench/motion_sensor_config_regs_bench.sv
// self-checking bench for the motion sensor configuration registers
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin err_count++; \
  $display("BAD %s exp %h got %h", n, e, g); end end
module motion_sensor_config_regs_bench import motion_cfg_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int UNIT = 4;
  logic clk = 1'b0, rst_n = 1'b0, wr_s = 1'b0, rd_s = 1'b0, aux_ro = 1'b0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
  logic [12:0] fill = 13'h0000, wtm;
  logic [3:0] acc_rate, gyr_rate, aux_rate;
  logic [2:0] acc_avg, gyr_rng, gyr_ds, acc_ds;
  logic [1:0] acc_filt, acc_rng, gyr_bw;
  logic acc_rv, acc_perf, gyr_rv, gyr_np, gyr_fp, gyr_ois, aux_rv, aux_trig;
  logic gyr_fs, acc_fs, irq;
  logic [12:0] rst_view;
  logic [63:0] rv = 64'h0200_8846_00a9_02a8;
  int err_count = 0, checked = 0;

  motion_sensor_config_regs #(.AUX_UNIT_CYCLES(UNIT)) i_dut (.CLK_I(clk),
    .RSTN_I(rst_n), .CE_I(1'b1), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr_s),
    .RD_I(rd_s), .RDATA_O(rdata), .FILL_BYTES_I(fill), .AUX_READOUT_I(aux_ro),
    .ACC_RATE_O(acc_rate), .ACC_RATE_VALID_O(acc_rv), .ACC_PERF_O(acc_perf),
    .ACC_FILTER_O(acc_filt), .ACC_AVG_LOG2_O(acc_avg), .ACC_RANGE_O(acc_rng),
    .GYR_RATE_O(gyr_rate), .GYR_RATE_VALID_O(gyr_rv), .GYR_BW_O(gyr_bw),
    .GYR_NOISE_PERF_O(gyr_np), .GYR_FILTER_PERF_O(gyr_fp),
    .GYR_RANGE_O(gyr_rng), .GYR_OIS_WIDE_O(gyr_ois), .AUX_RATE_O(aux_rate),
    .AUX_RATE_VALID_O(aux_rv), .AUX_TRIGGER_O(aux_trig), .GYR_DOWNS_O(gyr_ds),
    .ACC_DOWNS_O(acc_ds), .GYR_FILT_SEL_O(gyr_fs), .ACC_FILT_SEL_O(acc_fs),
    .WTM_LEVEL_O(wtm), .IRQ_O(irq));

  always #12.5 clk = ~clk;

  // decoded reset settings gathered for one compare
  assign rst_view = {acc_perf, acc_rng, gyr_rate, gyr_np, gyr_fp, aux_rate};

  // write, then wait until the decoded outputs have settled
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1;
    `CHK("rdata", e, rdata)
  endtask : rd

  // readout pulse, then count cycles until the trigger shows
  task automatic aux(input int n);
    int k;
    k = 1;
    wr(OFF_AUX_CFG, 8'(n << 4) | 8'h06);
    @(posedge clk);
    aux_ro <= 1'b1;
    @(posedge clk);
    aux_ro <= 1'b0;
    #1;
    while (aux_trig !== 1'b1 && k < 200)
    begin
      @(posedge clk);
      #1;
      k++;
    end
    `CHK("aux", n * UNIT + 1, k)
  endtask : aux

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : wrap_up

  initial
  begin
    #2000000;
    err_count++;
    wrap_up;
  end

  initial
  begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 8; i++) rd(8'h40 + 8'(i), rv[8*i +: 8]);
    rd(8'h50, 8'h00);
    `CHK("rst", 13'h1a56, rst_view)
    `CHK("rst2", 15'h6200, {gyr_fs, acc_fs, wtm})
    $display("reset values done");
    for (int c = 0; c < 16; c++)
    begin
      wr(OFF_ACC_CFG, 8'ha0 | 8'(c));
      wr(OFF_GYR_CFG, 8'ha0 | 8'(c));
      wr(OFF_AUX_CFG, 8'h40 | 8'(c));
      `CHK("acc_rv", c inside {[1:12]}, acc_rv)
      `CHK("gyr_rv", c inside {[6:13]}, gyr_rv)
      `CHK("aux_rv", c inside {[1:11]}, aux_rv)
    end
    wr(OFF_GYR_CFG, 8'ha9);
    wr(OFF_AUX_CFG, 8'h46);
    for (int i = 0; i < 16; i++)
    begin
      wr(OFF_ACC_CFG, {i[3:0], 4'h8});
      if (i[3])
      begin
        if (!i[2]) `CHK("filt", i[1:0], acc_filt)
        rd(OFF_CFG_ERR, {6'h00, i[2], 1'b0});
      end
      else `CHK("avg", {2'h2, i[2:0]}, {acc_filt, acc_avg})
    end
    wr(OFF_ACC_CFG, 8'ha8);
    for (int b = 0; b < 16; b++)
    begin
      wr(OFF_GYR_CFG, {b[3:0], 4'h9});
      `CHK("gyr", 4'(b), {gyr_fp, gyr_np, gyr_bw})
      rd(OFF_CFG_ERR, {4'h0, b[1:0] == 2'h3, 3'h0});
    end
    wr(OFF_GYR_CFG, 8'ha9);
    for (int r = 0; r < 16; r++)
    begin
      wr(OFF_GYR_SCALE, 8'hf0 | 8'(r));
      `CHK("grng", 4'(r), {gyr_ois, gyr_rng})
      rd(OFF_GYR_SCALE, 8'(r));
      rd(OFF_CFG_ERR, {3'h0, r[2:0] > 3'h4, 4'h0});
    end
    wr(OFF_GYR_SCALE, 8'h00);
    wr(OFF_ACC_SCALE, 8'hff);
    rd(OFF_ACC_SCALE, 8'h03);
    `CHK("arng", 2'h3, acc_rng)
    wr(OFF_DECIM, 8'h35);
    `CHK("dec", 8'h35, {acc_fs, acc_ds, gyr_fs, gyr_ds})
    wr(OFF_DECIM, 8'hca);
    `CHK("dec", 8'hca, {acc_fs, acc_ds, gyr_fs, gyr_ds})
    $display("decode tests done");
    wr(OFF_IRQ_STAT, 8'h03);
    wr(OFF_THR_LO, 8'h10);
    wr(OFF_THR_HI, 8'he1);
    rd(OFF_THR_HI, 8'h01);
    `CHK("wtm", 13'h0110, wtm)
    wr(OFF_IRQ_MASK, 8'h01);
    fill <= 13'h010f;
    repeat (3) @(posedge clk);
    #1;
    `CHK("irq", 1'b0, irq)
    fill <= 13'h0110;
    repeat (3) @(posedge clk);
    #1;
    `CHK("irq", 1'b1, irq)
    rd(OFF_IRQ_STAT, 8'h01);
    wr(OFF_IRQ_STAT, 8'h01);
    `CHK("irq", 1'b0, irq)
    wr(OFF_IRQ_MASK, 8'h02);
    wr(OFF_ACC_CFG, 8'ha0);
    `CHK("irq", 1'b1, irq)
    rd(OFF_IRQ_STAT, 8'h02);
    $display("interrupt tests done");
    aux(0);
    aux(1);
    aux(15);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rd(OFF_ACC_SCALE, 8'h02);
    rd(OFF_IRQ_MASK, 8'h00);
    $display("aux and second reset done");
    wrap_up;
  end
endmodule : motion_sensor_config_regs_bench
